// ### bench/config_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module config_host_model (
  input  wire logic        dataPin,
  output logic             serialBitClock,
  output logic [15:0]      shiftIn
);
  // ----------------------------------------
  // bit clock, idle low, pulsed only by pulse_bits, also while deselected
  // ----------------------------------------
  initial
  begin
    serialBitClock = 1'h0;
    shiftIn        = 16'h0000;
  end

  // sample before the rise, as the configuring side does
  task automatic pulse_bits(input int n, input bit keep);
    for (int i = 0; i < n; i++)
    begin
      if (keep)
        shiftIn = {shiftIn[14:0], dataPin};
      serialBitClock = 1'h1;
      #80;
      serialBitClock = 1'h0;
      #80;
    end
  endtask
endmodule // config_host_model

`default_nettype wire

// ### bench/serial_config_readout_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      errorCnt++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module serial_config_readout_tb;
  import serial_config_readout_pkg::*;

  logic        clock;
  logic        resetn;
  logic        resetOe;
  logic        chipSelectN;
  logic        serialProgramEnableN;
  logic        pageEnable;
  logic [1:0]  pageSelect;
  logic        programmingDeviceSelect;
  load_s       loadIn;
  logic        dataOut;
  logic        dataOe;
  logic        cascadeOutN;
  logic        standby;
  logic        readyOe;
  logic        serialBitClockOut;
  logic        serialBitClockOe;
  logic        serialBitClock;
  logic        dataPin;
  logic [15:0] shiftIn;
  int          errorCnt;
  int          comparisons;

  // pin has a pull-up
  assign dataPin = dataOe ? dataOut : 1'h1;

  serial_config_readout i_serial_config_readout (
    .clock(clock), .resetn(resetn), .serialBitClockIn(serialBitClock),
    .serialBitClockOut(serialBitClockOut), .serialBitClockOe(serialBitClockOe),
    .resetOe(resetOe), .chipSelectN(chipSelectN),
    .serialProgramEnableN(serialProgramEnableN), .pageEnable(pageEnable),
    .pageSelect(pageSelect), .programmingDeviceSelect(programmingDeviceSelect),
    .loadIn(loadIn), .dataOut(dataOut), .dataOe(dataOe), .cascadeOutN(cascadeOutN),
    .standby(standby), .readyOe(readyOe)
  );

  config_host_model i_config_host_model (
    .dataPin(dataPin), .serialBitClock(serialBitClock), .shiftIn(shiftIn)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial
  begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  function automatic logic [15:0] pat(input logic [19:0] a);
    return a[15:0] ^ {a[19:18], 14'h1A5C};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic put_word(input logic [19:0] a, input logic [15:0] w);
    loadIn = '{valid: 1'h1, addr: a, word: w};
    cyc(1);
    loadIn.valid = 1'h0;
    cyc(1);
  endtask

  task automatic get(input int n);
    i_config_host_model.pulse_bits(n, 1'b1);
    cyc(2);
  endtask

  task automatic skip(input int n);
    i_config_host_model.pulse_bits(n, 1'b0);
    cyc(2);
  endtask

  task automatic restart();
    resetOe = 1'h0;
    cyc(4);
    resetOe = 1'h1;
    cyc(10);
  endtask

  task automatic summarize();
    $display("comparisons %0d, errors %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #400000;
    errorCnt++;
    summarize();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    resetn = 1'h0;
    resetOe = 1'h1;
    chipSelectN = 1'h0;
    serialProgramEnableN = 1'h0;
    pageEnable = 1'h0;
    pageSelect = 2'h0;
    programmingDeviceSelect = 1'h1;
    loadIn = '0;
    errorCnt = 0;
    comparisons = 0;
    cyc(12);
    resetn = 1'h1;
    cyc(25);
    for (int p = 0; p < 4; p++)
      put_word({p[1:0], 18'h00000}, pat({p[1:0], 18'h00000}));
    put_word(20'h00001, pat(20'h00001));
    put_word(20'h00002, pat(20'h00002));
    programmingDeviceSelect = 1'h0;
    cyc(3);
    put_word(20'h00001, 16'hDEAD);
    cyc(4);
    `CHK(dataOe, 1'h0)
    chipSelectN = 1'h1;
    cyc(4);
    `CHK(standby, 1'h0)
    `CHK(dataOe, 1'h0)
    serialProgramEnableN = 1'h1;
    resetn = 1'h0;
    cyc(12);
    resetn = 1'h1;
    chipSelectN = 1'h0;
    cyc(5);
    `CHK(readyOe, 1'h1)
    cyc(20);
    `CHK(readyOe, 1'h0)
    `CHK(serialBitClockOe, 1'h0)
    `CHK(serialBitClockOut, 1'h0)
    `CHK(dataOe, 1'h1)
    get(16);
    `CHK(shiftIn, pat(20'h00000))
    get(16);
    `CHK(shiftIn, pat(20'h00001))
    get(8);
    chipSelectN = 1'h1;
    cyc(6);
    `CHK(standby, 1'h1)
    `CHK(dataOe, 1'h0)
    skip(4);
    chipSelectN = 1'h0;
    cyc(8);
    get(8);
    `CHK(shiftIn, pat(20'h00002))
    resetOe = 1'h0;
    cyc(6);
    `CHK(dataOe, 1'h0)
    chipSelectN = 1'h1;
    cyc(4);
    resetOe = 1'h1;
    cyc(8);
    `CHK(dataOe, 1'h0)
    skip(3);
    chipSelectN = 1'h0;
    cyc(10);
    `CHK(dataOe, 1'h1)
    get(16);
    `CHK(shiftIn, pat(20'h00000))
    pageEnable = 1'h1;
    for (int p = 0; p < 4; p++)
    begin
      pageSelect = p[1:0];
      restart();
      get(8);
      pageSelect = ~pageSelect;
      get(8);
      `CHK(shiftIn, pat({p[1:0], 18'h00000}))
      `CHK(cascadeOutN, 1'h1)
    end
    pageEnable = 1'h0;
    pageSelect = 2'h3;
    restart();
    get(16);
    `CHK(shiftIn, pat(20'h00000))
    summarize();
  end
endmodule // serial_config_readout_tb

`default_nettype wire

// ### logic/config_bit_store.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_config_readout_params.svh"

module config_bit_store (
  input  wire logic                                  clock,
  input  wire logic                                  rdEn,
  input  wire logic [`ADDR_W-1:0]                    rdAddr,
  output logic      [`WORD_W-1:0]                    rdData,
  input  wire serial_config_readout_pkg::load_s      load
);
  import serial_config_readout_pkg::*;

  typedef struct packed {
    logic [`WORD_W-1:0] rdData;
  } store_state_s;

  logic [`WORD_W-1:0] mem [0:`MEM_DEPTH-1];
  store_state_s r;
  store_state_s n;

  always_comb
  begin
    n = r;
    if (rdEn)
    begin
      n.rdData = mem[rdAddr];
    end
  end

  always_ff @(posedge clock)
  begin
    r <= n;
    if (load.valid)
    begin
      mem[load.addr] <= load.word;
    end
  end

  assign rdData = r.rdData;

endmodule // config_bit_store

`default_nettype wire

// ### logic/serial_config_readout.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_config_readout_params.svh"

module serial_config_readout (
  input  wire logic                                  clock,
  input  wire logic                                  resetn,
  input  wire logic                                  serialBitClockIn,
  output logic                                       serialBitClockOut,
  output logic                                       serialBitClockOe,
  input  wire logic                                  resetOe,
  input  wire logic                                  chipSelectN,
  input  wire logic                                  serialProgramEnableN,
  input  wire logic                                  pageEnable,
  input  wire logic [1:0]                            pageSelect,
  input  wire logic                                  programmingDeviceSelect,
  input  wire serial_config_readout_pkg::load_s      loadIn,
  output logic                                       dataOut,
  output logic                                       dataOe,
  output logic                                       cascadeOutN,
  output logic                                       standby,
  output logic                                       readyOe
);
  import serial_config_readout_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    pins_s                  sync1;
    pins_s                  sync2;
    logic                   clkPrev;
    phase_e                 phase;
    page_window_s           win;
    logic [`ADDR_W-1:0]     fetchAddr;
    logic                   fetchDone;
    logic                   rdPending;
    logic [`WORD_W-1:0]     buf0;
    logic [`WORD_W-1:0]     buf1;
    logic [1:0]             bufCount;
    logic [`WORD_W-1:0]     curWord;
    logic                   curValid;
    logic [`ADDR_W-1:0]     wordAddr;
    logic [`BIT_W-1:0]      bitCnt;
    logic                   dataOut;
    logic                   dataOe;
    logic                   cascadeOutN;
    logic                   standby;
    logic                   readyOe;
    logic                   clkOut;
    logic                   clkOe;
    logic [`POR_CNT_W-1:0]  porCnt;
  } readout_state_s;

  readout_state_s r;
  readout_state_s n;

  logic [`WORD_W-1:0] rdData;
  logic               rdIssue;
  logic               countEdge;
  logic               clearCounters;
  logic               popWord;
  logic               bufReady;
  load_s              loadGated;
  pins_s              pinsRaw;

  // ----------------------------------------------------------------
  // page decoding
  // ----------------------------------------------------------------
  function automatic page_window_s pageWindow(input logic en, input logic [1:0] sel);
    page_window_s w;
    if (en)
    begin
      w.base = {sel, 18'h00000};
      w.top  = {sel, `PAGE_TOP};
    end
    else
    begin
      w.base = 20'h00000;
      w.top  = `DEVICE_TOP;
    end
    return w;
  endfunction

  assign pinsRaw = '{serialBitClock:          serialBitClockIn,
                     resetOe:                 resetOe,
                     chipSelectN:             chipSelectN,
                     serialProgramEnableN:    serialProgramEnableN,
                     pageEnable:              pageEnable,
                     pageSelect:              pageSelect,
                     programmingDeviceSelect: programmingDeviceSelect};

  // ----------------------------------------------------------------
  // programming path
  // ----------------------------------------------------------------
  always_comb
  begin
    loadGated = loadIn;
    // only a selected device in programming mode takes words
    loadGated.valid = loadIn.valid && !r.sync2.serialProgramEnableN
                      && r.sync2.programmingDeviceSelect;
  end

  config_bit_store i_config_bit_store (
    .clock  (clock),
    .rdEn   (rdIssue),
    .rdAddr (r.fetchAddr),
    .rdData (rdData),
    .load   (loadGated)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.sync1   = pinsRaw;
    n.sync2   = r.sync1;
    n.clkPrev = r.sync2.serialBitClock;

    clearCounters = 1'b0;
    countEdge     = 1'b0;
    popWord       = 1'b0;
    bufReady      = ({1'b0, r.bufCount} + {2'b00, r.rdPending}) < 3'd2;
    rdIssue       = 1'b0;

    if (r.sync2.serialProgramEnableN)
    begin
      // cleared whenever reset/oe is low outside programming mode, and after power-up or programming
      if (!r.sync2.resetOe || r.phase == PH_RESET || r.phase == PH_PROG)
      begin
        clearCounters = 1'b1;
      end
    end

    if (!r.sync2.serialProgramEnableN)
    begin
      n.phase     = PH_PROG;
      n.curValid  = 1'b0;
      n.bufCount  = 2'd0;
      n.rdPending = 1'b0;
    end
    else if (clearCounters)
    begin
      // window captured on every cycle the counters clear, then held while counting
      n.win       = pageWindow(r.sync2.pageEnable, r.sync2.pageSelect);
      n.wordAddr  = n.win.base;
      n.fetchAddr = n.win.base;
      n.bitCnt    = '0;
      n.curValid  = 1'b0;
      n.bufCount  = 2'd0;
      n.rdPending = 1'b0;
      n.fetchDone = 1'b0;
      n.phase     = r.sync2.resetOe ? PH_RUN : PH_RESET;
    end
    else
    begin
      // prefetch into the two-entry buffer while it has room
      rdIssue     = r.phase != PH_PROG && !r.fetchDone && bufReady;
      n.rdPending = rdIssue;
      if (rdIssue)
      begin
        n.fetchDone = r.fetchAddr == r.win.top;
        n.fetchAddr = r.fetchAddr + 20'h00001;
      end

      // counting only with select low and oe high
      countEdge = r.phase == PH_RUN && r.curValid && !r.sync2.chipSelectN
                  && r.sync2.resetOe && r.sync2.serialBitClock && !r.clkPrev;

      if (countEdge)
      begin
        if (r.bitCnt == `BIT_LAST)
        begin
          if (r.wordAddr == r.win.top)
          begin
            n.phase    = PH_DONE;
            n.curValid = 1'b0;
          end
          else
          begin
            n.wordAddr = r.wordAddr + 20'h00001;
            n.bitCnt   = '0;
            n.curValid = 1'b0;
            popWord    = r.bufCount != 2'd0;
          end
        end
        else
        begin
          n.bitCnt = r.bitCnt + 4'h1;
        end
      end
      else if (r.phase == PH_RUN && !r.curValid && r.bufCount != 2'd0)
      begin
        popWord = 1'b1;
      end

      if (popWord)
      begin
        n.curWord  = r.buf0;
        n.curValid = 1'b1;
        n.buf0     = r.buf1;
        n.bufCount = r.bufCount - 2'd1;
      end
      if (r.rdPending)
      begin
        if (n.bufCount == 2'd0)
        begin
          n.buf0 = rdData;
        end
        else
        begin
          n.buf1 = rdData;
        end
        n.bufCount = n.bufCount + 2'd1;
      end
    end

    // ----------------------------------------------------------------
    // pin outputs
    // ----------------------------------------------------------------
    n.dataOut = n.curWord[~n.bitCnt];
    // driver on only with select low, oe high and data left
    n.dataOe  = r.sync2.serialProgramEnableN && r.sync2.resetOe
                && !r.sync2.chipSelectN && n.phase == PH_RUN && n.curValid;
    // low after the end while selected, then follows select
    n.cascadeOutN = !(n.phase == PH_DONE && !r.sync2.chipSelectN);
    n.standby     = r.sync2.serialProgramEnableN && r.sync2.chipSelectN;
    // clock is always received from the configuring side
    n.clkOut      = 1'b0;
    n.clkOe       = 1'b0;
    if (r.porCnt != 8'(`POR_CYCLES))
    begin
      n.porCnt = r.porCnt + 8'h01;
    end
    n.readyOe = n.porCnt != 8'(`POR_CYCLES);
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      r             <= '0;
      r.phase       <= PH_RESET;
      r.win.top     <= `DEVICE_TOP;
      r.cascadeOutN <= 1'b1;
      r.readyOe     <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dataOut           = r.dataOut;
  assign dataOe            = r.dataOe;
  assign cascadeOutN       = r.cascadeOutN;
  assign standby           = r.standby;
  assign readyOe           = r.readyOe;
  assign serialBitClockOut = r.clkOut;
  assign serialBitClockOe  = r.clkOe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  chk_reset_clears:
    assert property (r.sync2.serialProgramEnableN && !r.sync2.resetOe
                     |=> r.bitCnt == 4'h0 && r.wordAddr == r.win.base ##1 !r.dataOe)
    else $error("reset/oe low did not clear counters or float data");

  chk_select_float:
    assert property (r.sync2.chipSelectN && r.sync2.serialProgramEnableN |=> !r.dataOe)
    else $error("data driven with chip select high");

  chk_enable_drive:
    assert property (r.sync2.serialProgramEnableN && r.sync2.resetOe && !r.sync2.chipSelectN
                     && n.phase == PH_RUN && n.curValid |=> r.dataOe)
    else $error("driver not enabled with select low and oe high");

  chk_bit_advance:
    assert property (countEdge && r.bitCnt != `BIT_LAST |=> r.bitCnt == $past(r.bitCnt) + 4'h1)
    else $error("bit counter did not advance on serial clock");

  chk_standby_hold:
    assert property (r.sync2.chipSelectN && r.phase == PH_RUN && $stable(r.sync2)
                     |=> r.standby && r.bitCnt == $past(r.bitCnt))
    else $error("counter moved or standby missing with select high");

  chk_prog_mode:
    assert property (!r.sync2.serialProgramEnableN |=> !r.standby && !r.dataOe ##1 !r.dataOe)
    else $error("select acted in programming mode");

  chk_cascade_float:
    assert property (!r.cascadeOutN |-> !r.dataOe)
    else $error("data driven after cascade went low");

  chk_page_bounds:
    assert property (r.phase == PH_RUN |-> r.wordAddr >= r.win.base && r.wordAddr <= r.win.top)
    else $error("address left the selected page");

  chk_cascade_top:
    assert property (countEdge && r.bitCnt == `BIT_LAST && r.wordAddr == r.win.top
                     && !pinsRaw.chipSelectN && !r.sync1.chipSelectN
                     |=> !r.cascadeOutN)
    else $error("cascade did not go low at the top address");

  chk_ready_release:
    assert property (r.readyOe |-> r.porCnt < 8'(`POR_CYCLES))
    else $error("ready held low past the power-on cycle");

  chk_cascade_restore:
    assert property (r.sync2.serialProgramEnableN && !r.sync2.resetOe |=> r.cascadeOutN)
    else $error("cascade low while reset/oe low");

  chk_cascade_follow:
    assert property (r.phase == PH_DONE && r.sync2.serialProgramEnableN && r.sync2.resetOe
                     |=> r.cascadeOutN == $past(r.sync2.chipSelectN))
    else $error("cascade did not follow chip select after the end");

  chk_clock_received:
    assert property (!serialBitClockOe && !serialBitClockOut)
    else $error("serial clock pin driven");

  chk_page_window:
    assert property (clearCounters && r.sync2.pageEnable
                     |=> r.win.base == {$past(r.sync2.pageSelect), 18'h00000}
                         && r.win.top == {$past(r.sync2.pageSelect), `PAGE_TOP})
    else $error("paged window does not match page select");

  chk_full_window:
    assert property (clearCounters && !r.sync2.pageEnable
                     |=> r.win.base == 20'h00000 && r.win.top == `DEVICE_TOP)
    else $error("unpaged window does not cover the device");

  chk_window_hold:
    assert property (r.phase == PH_RUN && !clearCounters && r.sync2.serialProgramEnableN
                     |=> r.win == $past(r.win))
    else $error("page window changed during a download");

  chk_prog_paging:
    assert property (!r.sync2.serialProgramEnableN |=> r.win == $past(r.win))
    else $error("paging inputs acted in programming mode");

endmodule // serial_config_readout

`default_nettype wire

// ### logic/serial_config_readout_params.svh
`ifndef SERIAL_CONFIG_READOUT_PARAMS_SVH
`define SERIAL_CONFIG_READOUT_PARAMS_SVH

`define ADDR_W       20
`define WORD_W       16
`define BIT_W        4
`define MEM_DEPTH    (1 << `ADDR_W)
`define PAGE_TOP     18'h3FFFF
`define DEVICE_TOP   20'hFFFFF
`define BIT_LAST     4'hF
`define CLOCK_NS     10
`define POR_NS       200
`define POR_CYCLES   ((`POR_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`define POR_CNT_W    8

`endif

// ### logic/serial_config_readout_pkg.sv
`default_nettype none
`include "serial_config_readout_params.svh"

package serial_config_readout_pkg;

  typedef enum logic [1:0] {
    PH_RESET = 2'b00,
    PH_RUN   = 2'b01,
    PH_DONE  = 2'b10,
    PH_PROG  = 2'b11
  } phase_e;

  // pins after the two-flop synchroniser
  typedef struct packed {
    logic       serialBitClock;
    logic       resetOe;
    logic       chipSelectN;
    logic       serialProgramEnableN;
    logic       pageEnable;
    logic [1:0] pageSelect;
    logic       programmingDeviceSelect;
  } pins_s;

  typedef struct packed {
    logic [`ADDR_W-1:0] base;
    logic [`ADDR_W-1:0] top;
  } page_window_s;

  typedef struct packed {
    logic               valid;
    logic [`ADDR_W-1:0] addr;
    logic [`WORD_W-1:0] word;
  } load_s;

endpackage

`default_nettype wire
